// ===== rtl/eepr_pkg.sv
/*
  Constants, types and state codes for the serial EEPROM slave.
  Assumes one 250 MHz system clock; bus pins arrive asynchronous.
*/

`default_nettype none

package eepr_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          MEM_DEPTH     = 256;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          PAGE_BITS     = 4;
  localparam logic [3:0]  DEV_CODE      = 4'ha;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam int          RW_BIT        = 0;
  localparam int          CS_LSB        = 1;
  localparam int          CODE_LSB      = 4;
  localparam logic [4:0]  PIN_IDLE      = 5'h03;
  localparam logic        SDA_LOW       = 1'b0;

  // ====================================================================
  // Write cycle timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          T_WRITE_US    = 1000;
  localparam int          WR_CYCLES     = (T_WRITE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TMR_W         = 18;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eepr_wr_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CTRL, ST_CACK, ST_ADDR, ST_AACK,
    ST_WDATA, ST_DACK, ST_RDATA, ST_RACK, ST_IGNORE
  } eepr_state_e;

endpackage

`default_nettype wire

// ===== rtl/eepr_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a clear.
  Assumes one clock; clear and push never need to coexist usefully.
*/
`timescale 1ns/1ns
`default_nettype none

module eepr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic             s_valid_i,
  input  wire logic [WIDTH-1:0] s_data_i,
  output logic                  s_ready_o,
  output logic                  m_valid_o,
  input  wire logic             m_ready_i,
  output logic      [WIDTH-1:0] m_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r, wp_nxt;
  logic [AW:0]      rp_r, rp_nxt;
  logic             push;
  logic             pop;

  assign s_ready_o = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign m_valid_o = (wp_r != rp_r);
  assign m_data_o  = mem[rp_r[AW-1:0]];
  assign push      = s_valid_i && s_ready_o;
  assign pop       = m_valid_o && m_ready_i;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (clear_i) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = wp_r + 1'b1;
      end
      if (pop) begin
        rp_nxt = rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !clear_i) begin
      mem[wp_r[AW-1:0]] <= s_data_i;
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (rst_i)
      (!s_ready_o && s_valid_i && !pop && !clear_i) |=> ($stable(wp_r) && !s_ready_o);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo wrote while full");

endmodule // eepr_fifo

`default_nettype wire

// ===== rtl/eepr_slave.sv
/*
  Two-wire serial EEPROM slave: control byte decode, address pointer,
  write cycle with acknowledge polling, and the three read forms.
  Assumes the bus master drives SCL and START/STOP; SDA is open drain
  and the wire is resolved outside from sda_oe_o.
*/
`timescale 1ns/1ns
`default_nettype none

module eepr_slave
  import eepr_pkg::*;
#(
  parameter int WR_CYC = WR_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [2:0] chip_select_pins_i,
  output logic            busy_o
);

  // ====================================================================
  // Pin synchronisers and bus condition detection
  logic [4:0]  pin_raw;
  logic [4:0]  sync1_r;
  logic [4:0]  sync2_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        scl_q;
  logic        sda_q;
  logic [2:0]  cs_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  assign pin_raw = {chip_select_pins_i, sda_i, scl_i};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[0];
      sda_d_r <= sync2_r[1];
    end
  end

  assign scl_q     = sync2_r[0];
  assign sda_q     = sync2_r[1];
  assign cs_q      = sync2_r[4:2];
  assign scl_rise  = scl_q && !scl_d_r;
  assign scl_fall  = !scl_q && scl_d_r;
  // SDA moving while SCL stays high marks START or STOP
  assign start_det = scl_q && scl_d_r && sda_d_r && !sda_q;
  assign stop_det  = scl_q && scl_d_r && !sda_d_r && sda_q;

  // ====================================================================
  // Array, write buffer and write cycle
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rd_byte;
  logic              busy_r;
  logic              busy_nxt;
  logic [TMR_W-1:0]  tmr_r;
  logic [TMR_W-1:0]  tmr_nxt;
  logic              go_write;
  logic              push;
  logic              fifo_ready;
  logic              fifo_valid;
  logic              fifo_clear;
  eepr_wr_s          wr_in;
  eepr_wr_s          wr_out;

  eepr_state_e       state_r;
  eepr_state_e       state_nxt;
  logic [3:0]        cnt_r;
  logic [3:0]        cnt_nxt;
  logic [DATA_W-1:0] shreg_r;
  logic [DATA_W-1:0] shreg_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              drive_r;
  logic              drive_nxt;
  logic              armed_r;
  logic              armed_nxt;
  logic              acked_r;
  logic              acked_nxt;
  logic              rx_state;
  logic              byte_end;
  logic              ctrl_ok;
  logic              load;

  assign rd_byte    = mem[addr_r];
  assign wr_in      = '{addr: addr_r, data: shreg_r};
  // A repeated START drops buffered bytes that no STOP committed
  assign fifo_clear = start_det && !busy_r;

  // Back-pressure: a full buffer refuses the byte, seen as no acknowledge
  eepr_fifo #(
    .WIDTH ($bits(eepr_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i     (ref_clk_i),
    .rst_i     (rst_i),
    .clear_i   (fifo_clear),
    .s_valid_i (push),
    .s_data_i  (wr_in),
    .s_ready_o (fifo_ready),
    .m_valid_o (fifo_valid),
    .m_ready_i (busy_r),
    .m_data_o  (wr_out)
  );

  always_ff @(posedge ref_clk_i) begin
    if (busy_r && fifo_valid) begin
      mem[wr_out.addr] <= wr_out.data;
    end
  end

  always_comb begin
    busy_nxt = busy_r;
    tmr_nxt  = tmr_r;
    if (!busy_r) begin
      if (go_write) begin
        busy_nxt = 1'b1;
        tmr_nxt  = TMR_W'(WR_CYC - 1);
      end
    end else if (tmr_r != '0) begin
      tmr_nxt = tmr_r - 1'b1;
    end else if (!fifo_valid) begin
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      tmr_r  <= '0;
    end else begin
      busy_r <= busy_nxt;
      tmr_r  <= tmr_nxt;
    end
  end

  // ====================================================================
  // Protocol state machine
  assign rx_state = (state_r == ST_CTRL) || (state_r == ST_ADDR) || (state_r == ST_WDATA);
  assign byte_end = rx_state && scl_fall && (cnt_r == BYTE_BITS);
  assign ctrl_ok  = (shreg_r[DATA_W-1:CODE_LSB] == DEV_CODE) &&
                    (shreg_r[CODE_LSB-1:CS_LSB] == cs_q);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = shreg_r;
    addr_nxt  = addr_r;
    drive_nxt = drive_r;
    armed_nxt = armed_r;
    acked_nxt = acked_r;
    push      = 1'b0;
    load      = 1'b0;
    go_write  = 1'b0;
    if (start_det) begin
      state_nxt = ST_CTRL;
      cnt_nxt   = '0;
      drive_nxt = 1'b0;
      armed_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      armed_nxt = 1'b0;
      go_write  = armed_r;
    end else begin
      if (rx_state && scl_rise && (cnt_r != BYTE_BITS)) begin
        shreg_nxt = {shreg_r[DATA_W-2:0], sda_q};
        cnt_nxt   = cnt_r + 1'b1;
      end
      case (state_r)
        ST_CTRL: begin
          if (byte_end) begin
            if (ctrl_ok && !busy_r) begin
              state_nxt = ST_CACK;
              drive_nxt = 1'b1;
            end else begin
              state_nxt = ST_IGNORE;
            end
          end
        end
        ST_CACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (shreg_r[RW_BIT]) begin
              load = 1'b1;
            end else begin
              state_nxt = ST_ADDR;
              drive_nxt = 1'b0;
            end
          end
        end
        ST_ADDR: begin
          if (byte_end) begin
            addr_nxt  = shreg_r;
            armed_nxt = 1'b1;
            drive_nxt = 1'b1;
            state_nxt = ST_AACK;
          end
        end
        ST_AACK, ST_DACK: begin
          if (scl_fall) begin
            drive_nxt = 1'b0;
            cnt_nxt   = '0;
            state_nxt = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_end) begin
            push      = 1'b1;
            drive_nxt = fifo_ready;
            state_nxt = ST_DACK;
            if (fifo_ready) begin
              // Writes stay inside the current page
              addr_nxt = {addr_r[ADDR_W-1:PAGE_BITS], addr_r[PAGE_BITS-1:0] + 1'b1};
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == LAST_BIT) begin
              state_nxt = ST_RACK;
              drive_nxt = 1'b0;
            end else begin
              shreg_nxt = {shreg_r[DATA_W-2:0], 1'b0};
              drive_nxt = !shreg_r[DATA_W-2];
              cnt_nxt   = cnt_r + 1'b1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            acked_nxt = !sda_q;
          end else if (scl_fall) begin
            if (acked_r) begin
              load = 1'b1;
            end else begin
              state_nxt = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          drive_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
      if (load) begin
        state_nxt = ST_RDATA;
        shreg_nxt = rd_byte;
        drive_nxt = !rd_byte[DATA_W-1];
        cnt_nxt   = '0;
        acked_nxt = 1'b0;
        addr_nxt  = addr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      shreg_r <= '0;
      addr_r  <= '0;
      drive_r <= 1'b0;
      armed_r <= 1'b0;
      acked_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shreg_r <= shreg_nxt;
      addr_r  <= addr_nxt;
      drive_r <= drive_nxt;
      armed_r <= armed_nxt;
      acked_r <= acked_nxt;
    end
  end

  assign sda_o    = SDA_LOW;
  assign sda_oe_o = drive_r;
  assign busy_o   = busy_r;

  // ====================================================================
  // Checks
  property p_ctrl_ack;
    @(posedge ref_clk_i) disable iff (rst_i)
      (byte_end && state_r == ST_CTRL && ctrl_ok && !busy_r && !start_det && !stop_det)
      |=> (sda_oe_o && state_r == ST_CACK);
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack) else $error("matching control byte not acked");

  property p_busy_nack;
    @(posedge ref_clk_i) disable iff (rst_i)
      (byte_end && state_r == ST_CTRL && busy_r && !start_det && !stop_det)
      |=> (!sda_oe_o && state_r == ST_IGNORE);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("control byte acked while busy");

  property p_addr_load;
    @(posedge ref_clk_i) disable iff (rst_i)
      (byte_end && state_r == ST_ADDR && !start_det && !stop_det)
      |=> (addr_r == $past(shreg_r) && sda_oe_o && armed_r);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("word address not loaded");

  property p_stop_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      (stop_det && armed_r && !busy_r) |=> (busy_r && tmr_r == TMR_W'(WR_CYC - 1));
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("write cycle did not start");

  property p_sr_no_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      (start_det && !busy_r) |=> (!armed_r && !busy_r ##1 !busy_r);
  endproperty
  a_sr_no_write: assert property (p_sr_no_write) else $error("restart began a write");

  property p_load_inc;
    @(posedge ref_clk_i) disable iff (rst_i)
      load |=> (addr_r == ADDR_W'($past(addr_r) + 1'b1) && shreg_r == $past(rd_byte)
                && sda_oe_o == !$past(rd_byte[DATA_W-1]));
  endproperty
  a_load_inc: assert property (p_load_inc) else $error("read byte or pointer wrong");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (rst_i)
      (load && addr_r == '1) |=> (addr_r == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_release;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_IGNORE || state_r == ST_RACK || state_r == ST_IDLE) |-> !sda_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("data line held when it must be free");

  property p_nack_end;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_RACK && scl_fall && !acked_r && !start_det && !stop_det)
      |=> (state_r == ST_IGNORE && !sda_oe_o);
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read went on after no ack");

  property p_seq_next;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_RACK && scl_fall && acked_r && !start_det && !stop_det)
      |=> (state_r == ST_RDATA && cnt_r == '0);
  endproperty
  a_seq_next: assert property (p_seq_next) else $error("ack did not fetch next byte");

  property p_drive_low_clk;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_RDATA && scl_q && scl_d_r) |=> $stable(sda_oe_o);
  endproperty
  a_drive_low_clk: assert property (p_drive_low_clk) else $error("data moved with clock high");

endmodule // eepr_slave

`default_nettype wire

// ===== verification/eepr_bus_master.sv
/*
  Bus master model for the serial EEPROM slave: START, STOP, byte
  send and byte receive, SCL period 40 clocks (160 ns at 250 MHz).
  Assumes the bench resolves the open-drain data wire and feeds sda_i.
*/
`timescale 1ns/1ns
`default_nettype none

module eepr_bus_master (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ==================================================================
  // Idle bus: both lines released high, SCL still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // ==================================================================
  // Conditions; also serves as repeated START from SCL low
  task automatic start();
    sda_o = 1'b1;
    tick(10);
    scl_o = 1'b1;
    tick(20);
    sda_o = 1'b0;
    tick(20);
    scl_o = 1'b0;
    tick(10);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    tick(10);
    scl_o = 1'b1;
    tick(20);
    sda_o = 1'b1;
    tick(20);
  endtask

  // ==================================================================
  // Data changes only mid-way through SCL low, sampled mid SCL high
  task automatic bit_xfer(input logic b, output logic s);
    sda_o = b;
    tick(10);
    scl_o = 1'b1;
    tick(10);
    s = sda_i;
    tick(10);
    scl_o = 1'b0;
    tick(10);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~give_ack, s);
  endtask
endmodule // eepr_bus_master

`default_nettype wire

// ===== verification/eepr_slave_tb.sv
/*
  Self-checking bench for the EEPROM slave: polling, random, current
  and sequential reads, pointer wrap and refused control bytes.
  Assumes eepr_bus_master drives the bus; write cycle shortened.
*/
`timescale 1ns/1ns
`default_nettype none

module eepr_slave_tb
  import eepr_pkg::*;
;
  // Long enough that the first poll always lands inside the cycle
  localparam int         WR_SIM = 2000;
  localparam logic [2:0] CS     = 3'h5;

  logic       ref_clk;
  logic       rst;
  logic       scl;
  logic       sda_m;
  logic       sda_d;
  logic       sda_oe;
  logic       busy;
  logic       sda_w;
  logic       watch;
  logic       oe_seen;
  logic [2:0] cs_pins;
  logic       ack;
  logic [7:0] d;
  int         err_count;
  int         check_count;

  // Pull-up wire: the slave only ever pulls to its sda_o level
  assign sda_w = sda_m & (sda_oe ? sda_d : 1'b1);

  eepr_slave #(.WR_CYC(WR_SIM)) dut_u (
    .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
    .sda_oe_o(sda_oe), .chip_select_pins_i(cs_pins), .busy_o(busy));

  eepr_bus_master m_u (.ref_clk_i(ref_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (!watch) begin
      oe_seen <= 1'b0;
    end else if (sda_oe) begin
      oe_seen <= 1'b1;
    end
  end

  // ==================================================================
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] ctrl(input logic [3:0] code, input logic rw);
    return {code, CS, rw};
  endfunction

  // ==================================================================
  // Bus sequences
  task automatic open_w();
    m_u.start();
    m_u.send_byte(ctrl(DEV_CODE, 1'b0), ack);
    check(ack, 1'b1, "write control ack");
  endtask

  // Leaves the frame open after the acknowledged poll
  task automatic wr_poll(input logic [7:0] a, input logic [7:0] q[$]);
    int tries;
    m_u.send_byte(a, ack);
    check(ack, 1'b1, "address ack");
    foreach (q[i]) begin
      m_u.send_byte(q[i], ack);
      check(ack, 1'b1, "data ack");
    end
    m_u.stop();
    check(busy, 1'b1, "cycle started after stop");
    m_u.start();
    m_u.send_byte(ctrl(DEV_CODE, 1'b0), ack);
    check(ack, 1'b0, "poll during cycle");
    tries = 0;
    while (!ack) begin
      tries++;
      if (tries > 40) begin
        check(ack, 1'b1, "poll never acknowledged");
        close_out();
      end
      m_u.start();
      m_u.send_byte(ctrl(DEV_CODE, 1'b0), ack);
    end
    check(busy, 1'b0, "poll ack after cycle");
  endtask

  task automatic rd_bytes(input logic [7:0] e[$]);
    m_u.send_byte(ctrl(DEV_CODE, 1'b1), ack);
    check(ack, 1'b1, "read control ack");
    foreach (e[i]) begin
      m_u.recv_byte(i != e.size() - 1, d);
      check(d, e[i], "read data");
    end
    m_u.stop();
    check(sda_oe, 1'b0, "released after nack and stop");
  endtask

  task automatic rd_from(input logic [7:0] a, input logic [7:0] e[$]);
    m_u.send_byte(a, ack);
    check(ack, 1'b1, "address ack");
    m_u.start();
    rd_bytes(e);
  endtask

  task automatic rd_cur(input logic [7:0] e[$]);
    m_u.start();
    rd_bytes(e);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_poll_random();
    open_w();
    wr_poll(8'h10, '{8'ha5, 8'h3c, 8'h0f});
    rd_from(8'h10, '{8'ha5});
    rd_cur('{8'h3c});
    $display("poll and random read done");
  endtask

  task automatic t_sequential();
    open_w();
    rd_from(8'h10, '{8'ha5, 8'h3c, 8'h0f});
    $display("sequential read done");
  endtask

  task automatic t_wrap();
    open_w();
    wr_poll(8'hff, '{8'h77});
    wr_poll(8'h00, '{8'h66, 8'h55});
    rd_from(8'hff, '{8'h77, 8'h66});
    $display("pointer wrap done");
  endtask

  task automatic t_refused();
    watch = 1'b1;
    m_u.start();
    m_u.send_byte({DEV_CODE, 3'h2, 1'b1}, ack);
    check(ack, 1'b0, "wrong chip select");
    m_u.send_byte(ctrl(DEV_CODE, 1'b1), ack);
    m_u.stop();
    check(oe_seen, 1'b0, "line released until next start");
    m_u.start();
    m_u.send_byte(ctrl(4'h5, 1'b0), ack);
    m_u.stop();
    check(ack, 1'b0, "wrong device code");
    check(oe_seen, 1'b0, "no drive on wrong code");
    watch = 1'b0;
    // Refused frames leave the pointer just past the wrap read
    rd_cur('{8'h55});
    $display("refused control bytes done");
  endtask

  initial begin
    err_count = 0;
    check_count = 0;
    watch = 1'b0;
    cs_pins = CS;
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_poll_random();
    t_sequential();
    t_wrap();
    t_refused();
    close_out();
  end
endmodule // eepr_slave_tb

`default_nettype wire
